// *** hdl/rxtp_regs_top.sv ***
// Register bank top: serial slave port, tuning and preamble registers, AFC hold
`timescale 1ns/1ns
module rxtp_regs_top
	import rxtp_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = 7'h38
) (
	input wire logic CLK_I,
	input wire logic ARST_N_I,
	input wire logic SCL_I,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE_O,
	input wire logic [7:0] SIGNAL_STRENGTH_I,
	input wire logic SIGNAL_STRENGTH_VLD_I,
	input wire logic ASK_MODE_I,
	input wire logic PREAMBLE_DET_I,
	input wire logic RX_RESTART_I,
	output logic AFC_RUN_O,
	output logic [23:0] LO_TUNING_WORD_O,
	output logic [4:0] SYNC_LENGTH_O,
	output logic [15:0] SYNC_PATTERN_O
);
	logic [1:0] rst_ff;
	logic rst_n;
	rxtp_pins_t pins_raw;
	rxtp_pins_t pins_s;
	logic scl_q_ff;
	logic sda_q_ff;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	rxtp_state_t state_ff;
	rxtp_state_t nxt_state;
	logic [3:0] bit_cnt_ff;
	logic [7:0] shift_ff;
	logic [7:0] tx_ff;
	logic [7:0] ptr_ff;
	logic [7:0] ptr_inc;
	logic [7:0] rd_cur;
	logic [7:0] rd_next;
	logic rw_ff;
	logic first_ff;
	logic nack_ff;
	logic sda_oe_ff;
	logic sda_o_ff;
	rxtp_wr_t wr;
	logic afc_hold_ff;
	logic [7:0] lo_high_ff;
	logic [7:0] lo_mid_ff;
	logic [7:0] lo_low_ff;
	logic [3:0] sync_len_ff;
	logic [7:0] sync_low_ff;
	logic [7:0] sync_high_ff;
	logic [7:0] signal_strength_ff;
	logic [4:0] sync_bits_ff;

	// Read decode, used both for the first byte and for auto-increment reads
	function automatic logic [7:0] reg_read(input logic [7:0] addr);
		logic [7:0] val;
		val = RXTP_READ_ZERO;
		case (addr)
			RXTP_OFS_AFC_HOLD: val[RXTP_AFC_HOLD_BIT] = afc_hold_ff;
			RXTP_OFS_LO_HIGH: val = lo_high_ff;
			RXTP_OFS_LO_MID: val = lo_mid_ff;
			RXTP_OFS_LO_LOW: val = lo_low_ff;
			RXTP_OFS_SYNC_LEN: val[RXTP_SYNC_LEN_W-1:0] = sync_len_ff;
			RXTP_OFS_SYNC_LOW: val = sync_low_ff;
			RXTP_OFS_SYNC_HIGH: val = sync_high_ff;
			RXTP_OFS_SIGNAL_STRENGTH: val = signal_strength_ff;
			default: val = RXTP_READ_ZERO;
		endcase
		return val;
	endfunction

	// Reset release through two flops; assertion stays asynchronous
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			rst_ff <= 2'h0;
		end else begin
			rst_ff <= {rst_ff[0], 1'b1};
		end
	end
	assign rst_n = rst_ff[1];

	// Pins are asynchronous to the core clock
	assign pins_raw = '{scl: SCL_I, sda: SDA_I};

	rxtp_sync #(
		.WIDTH($bits(rxtp_pins_t)),
		.STAGES(2)
	) u_sync (
		.clk_i(CLK_I),
		.rst_n_i(rst_n),
		.d_i(pins_raw),
		.q_o(pins_s)
	);

	// Edge history of the settled pin levels
	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			scl_q_ff <= 1'b1;
			sda_q_ff <= 1'b1;
		end else begin
			scl_q_ff <= pins_s.scl;
			sda_q_ff <= pins_s.sda;
		end
	end

	// Both pins pass the same chain, so their relative timing is preserved
	assign scl_rise = pins_s.scl && !scl_q_ff;
	assign scl_fall = !pins_s.scl && scl_q_ff;
	assign start_cond = pins_s.scl && scl_q_ff && sda_q_ff && !pins_s.sda;
	assign stop_cond = pins_s.scl && scl_q_ff && !sda_q_ff && pins_s.sda;

	// Protocol state; start and stop override everything
	always_comb begin
		nxt_state = state_ff;
		if (start_cond) begin
			nxt_state = RXTP_ST_ADDR;
		end else if (stop_cond) begin
			nxt_state = RXTP_ST_IDLE;
		end else if (scl_fall) begin
			case (state_ff)
				RXTP_ST_ADDR: begin
					if (bit_cnt_ff == RXTP_BITS_PER_BYTE) begin
						nxt_state = (shift_ff[7:1] == DEV_ADDR) ? RXTP_ST_ADDR_ACK : RXTP_ST_IDLE;
					end
				end
				RXTP_ST_ADDR_ACK: nxt_state = rw_ff ? RXTP_ST_READ : RXTP_ST_WRITE;
				RXTP_ST_WRITE: begin
					if (bit_cnt_ff == RXTP_BITS_PER_BYTE) begin
						nxt_state = RXTP_ST_WRITE_ACK;
					end
				end
				RXTP_ST_WRITE_ACK: nxt_state = RXTP_ST_WRITE;
				RXTP_ST_READ: begin
					if (bit_cnt_ff == RXTP_BITS_PER_BYTE) begin
						nxt_state = RXTP_ST_READ_ACK;
					end
				end
				RXTP_ST_READ_ACK: nxt_state = nack_ff ? RXTP_ST_IDLE : RXTP_ST_READ;
				RXTP_ST_IDLE: nxt_state = RXTP_ST_IDLE;
				default: nxt_state = RXTP_ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= RXTP_ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Bit sampling on rising clock; the count restarts at each byte boundary
	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			bit_cnt_ff <= 4'h0;
			shift_ff <= 8'h00;
			nack_ff <= 1'b0;
		end else if (start_cond || nxt_state != state_ff) begin
			bit_cnt_ff <= 4'h0;
		end else if (scl_rise) begin
			bit_cnt_ff <= bit_cnt_ff + 4'h1;
			shift_ff <= {shift_ff[6:0], pins_s.sda};
			if (state_ff == RXTP_ST_READ_ACK) begin
				nack_ff <= pins_s.sda; // High on the ack slot ends the read
			end
		end
	end

	// Direction bit captured at the end of the address byte
	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			rw_ff <= 1'b0;
		end else if (state_ff == RXTP_ST_ADDR && nxt_state == RXTP_ST_ADDR_ACK) begin
			rw_ff <= shift_ff[0];
		end
	end

	// Pointer: first written byte after the address sets it, later bytes auto-increment
	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			ptr_ff <= 8'h00;
			first_ff <= 1'b0;
		end else if (state_ff == RXTP_ST_ADDR_ACK && nxt_state == RXTP_ST_WRITE) begin
			first_ff <= 1'b1;
		end else if (state_ff == RXTP_ST_WRITE && nxt_state == RXTP_ST_WRITE_ACK) begin
			first_ff <= 1'b0;
			ptr_ff <= first_ff ? shift_ff : ptr_inc;
		end else if (state_ff == RXTP_ST_READ_ACK && nxt_state == RXTP_ST_READ) begin
			ptr_ff <= ptr_inc;
		end
	end

	// Read data at the pointer and the next one; a process, not an assign, so it sees register changes
	assign ptr_inc = ptr_ff + 8'h01;
	always_comb begin
		rd_cur = reg_read(ptr_ff);
		rd_next = reg_read(ptr_inc);
	end

	// Register write request, one cycle wide, at the end of each data byte
	assign wr.wr = state_ff == RXTP_ST_WRITE && nxt_state == RXTP_ST_WRITE_ACK && !first_ff;
	assign wr.addr = ptr_ff;
	assign wr.data = shift_ff;

	// Transmit byte; loaded ahead of the first data clock so bit 7 is already on the line
	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			tx_ff <= 8'h00;
		end else if (state_ff == RXTP_ST_ADDR_ACK && nxt_state == RXTP_ST_READ) begin
			tx_ff <= rd_cur;
		end else if (state_ff == RXTP_ST_READ_ACK && nxt_state == RXTP_ST_READ) begin
			tx_ff <= rd_next;
		end else if (state_ff == RXTP_ST_READ && scl_fall) begin
			tx_ff <= {tx_ff[6:0], 1'b0};
		end
	end

	// Open-drain drive: only ever pull low, enable reflects the bit being sent
	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			sda_oe_ff <= 1'b0;
			sda_o_ff <= 1'b0;
		end else begin
			sda_o_ff <= 1'b0;
			case (nxt_state)
				RXTP_ST_ADDR_ACK: sda_oe_ff <= 1'b1;
				RXTP_ST_WRITE_ACK: sda_oe_ff <= 1'b1;
				RXTP_ST_READ: begin
					if (state_ff == RXTP_ST_ADDR_ACK) begin
						sda_oe_ff <= !rd_cur[7];
					end else if (state_ff == RXTP_ST_READ_ACK) begin
						sda_oe_ff <= !rd_next[7];
					end else if (scl_fall) begin
						sda_oe_ff <= !tx_ff[6];
					end
				end
				default: sda_oe_ff <= 1'b0;
			endcase
		end
	end

	// AFC hold option; reserved low bits are not stored and read back zero
	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			afc_hold_ff <= RXTP_RST_AFC_HOLD;
		end else if (wr.wr && wr.addr == RXTP_OFS_AFC_HOLD) begin
			afc_hold_ff <= wr.data[RXTP_AFC_HOLD_BIT];
		end
	end

	// LO centre tuning word, three bytes written independently
	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			lo_high_ff <= RXTP_RST_LO_HIGH;
			lo_mid_ff <= RXTP_RST_LO_MID;
			lo_low_ff <= RXTP_RST_LO_LOW;
		end else if (wr.wr) begin
			if (wr.addr == RXTP_OFS_LO_HIGH) begin
				lo_high_ff <= wr.data;
			end
			if (wr.addr == RXTP_OFS_LO_MID) begin
				lo_mid_ff <= wr.data;
			end
			if (wr.addr == RXTP_OFS_LO_LOW) begin
				lo_low_ff <= wr.data;
			end
		end
	end

	// Preamble length field and pattern bytes
	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			sync_len_ff <= RXTP_RST_SYNC_LEN;
			sync_low_ff <= RXTP_RST_SYNC_LOW;
			sync_high_ff <= RXTP_RST_SYNC_HIGH;
		end else if (wr.wr) begin
			if (wr.addr == RXTP_OFS_SYNC_LEN) begin
				sync_len_ff <= wr.data[RXTP_SYNC_LEN_W-1:0];
			end
			if (wr.addr == RXTP_OFS_SYNC_LOW) begin
				sync_low_ff <= wr.data;
			end
			if (wr.addr == RXTP_OFS_SYNC_HIGH) begin
				sync_high_ff <= wr.data;
			end
		end
	end

	// Pattern length in bits, one cycle behind the field to keep the output registered
	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			sync_bits_ff <= {1'b0, RXTP_RST_SYNC_LEN} + RXTP_SYNC_LEN_ADD;
		end else begin
			sync_bits_ff <= {1'b0, sync_len_ff} + RXTP_SYNC_LEN_ADD;
		end
	end

	// Signal strength follows the demodulator only; the port write path never touches it
	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			signal_strength_ff <= RXTP_RST_SIGNAL_STRENGTH;
		end else if (SIGNAL_STRENGTH_VLD_I) begin
			signal_strength_ff <= SIGNAL_STRENGTH_I;
		end
	end

	rxtp_afc_hold u_afc_hold (
		.clk_i(CLK_I),
		.rst_n_i(rst_n),
		.hold_en_i(afc_hold_ff),
		.ask_mode_i(ASK_MODE_I),
		.preamble_det_i(PREAMBLE_DET_I),
		.rx_restart_i(RX_RESTART_I),
		.afc_run_o(AFC_RUN_O)
	);

	// Outputs straight from flops
	assign SDA_O = sda_o_ff;
	assign SDA_OE_O = sda_oe_ff;
	assign LO_TUNING_WORD_O = {lo_high_ff, lo_mid_ff, lo_low_ff};
	assign SYNC_LENGTH_O = sync_bits_ff;
	assign SYNC_PATTERN_O = {sync_high_ff, sync_low_ff};
endmodule

// *** include/rxtp_pkg.sv ***
// Package of constants and types for the receiver tuning and preamble register bank
package rxtp_pkg;

	// Register offsets on the serial port
	localparam logic [7:0] RXTP_OFS_AFC_HOLD = 8'h08;
	localparam logic [7:0] RXTP_OFS_LO_HIGH = 8'h09;
	localparam logic [7:0] RXTP_OFS_LO_MID = 8'h0a;
	localparam logic [7:0] RXTP_OFS_LO_LOW = 8'h0b;
	localparam logic [7:0] RXTP_OFS_SYNC_LEN = 8'h0c;
	localparam logic [7:0] RXTP_OFS_SYNC_LOW = 8'h0d;
	localparam logic [7:0] RXTP_OFS_SYNC_HIGH = 8'h0e;
	localparam logic [7:0] RXTP_OFS_SIGNAL_STRENGTH = 8'h10;

	// Reset values
	localparam logic RXTP_RST_AFC_HOLD = 1'h0;
	localparam logic [7:0] RXTP_RST_LO_HIGH = 8'h13;
	localparam logic [7:0] RXTP_RST_LO_MID = 8'ha9;
	localparam logic [7:0] RXTP_RST_LO_LOW = 8'h9a;
	localparam logic [3:0] RXTP_RST_SYNC_LEN = 4'hf;
	localparam logic [7:0] RXTP_RST_SYNC_LOW = 8'h00;
	localparam logic [7:0] RXTP_RST_SYNC_HIGH = 8'h00;
	localparam logic [7:0] RXTP_RST_SIGNAL_STRENGTH = 8'h00;

	// Field layout
	localparam int RXTP_AFC_HOLD_BIT = 6;
	localparam int RXTP_SYNC_LEN_W = 4;
	localparam logic [4:0] RXTP_SYNC_LEN_ADD = 5'h01;

	// Serial port framing
	localparam logic [3:0] RXTP_BITS_PER_BYTE = 4'h8;
	localparam logic [7:0] RXTP_READ_ZERO = 8'h00;

	// Serial port states, Gray coded along the usual path
	typedef enum logic [2:0] {
		RXTP_ST_IDLE = 3'h0,
		RXTP_ST_ADDR = 3'h1,
		RXTP_ST_ADDR_ACK = 3'h3,
		RXTP_ST_WRITE = 3'h2,
		RXTP_ST_WRITE_ACK = 3'h6,
		RXTP_ST_READ = 3'h7,
		RXTP_ST_READ_ACK = 3'h5
	} rxtp_state_t;

	// Serial pins as they travel through the synchroniser
	typedef struct packed {
		logic scl;
		logic sda;
	} rxtp_pins_t;

	// One register write from the serial port
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] data;
	} rxtp_wr_t;

endpackage

// *** hdl/rxtp_sync.sv ***
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ns
module rxtp_sync #(
	parameter int WIDTH = 2,
	parameter int STAGES = 2
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);
	logic [WIDTH-1:0] stage_ff [STAGES];
	logic [WIDTH-1:0] idle_val;

	// Refuse a chain too short to settle metastability
	if (STAGES < 2 || WIDTH < 1) begin : g_check
		$error("rxtp_sync needs at least two stages and one bit");
	end

	assign idle_val = '1;

	// Idle bus level is high, so reset to ones to avoid a false start
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < STAGES; i++) begin
				stage_ff[i] <= '1;
			end
		end else begin
			stage_ff[0] <= d_i;
			for (int i = 1; i < STAGES; i++) begin
				stage_ff[i] <= stage_ff[i-1];
			end
		end
	end

	assign q_o = stage_ff[STAGES-1] & idle_val;
endmodule

// *** hdl/rxtp_afc_hold.sv ***
// AFC hold control: gates synthesizer updates after a preamble
`timescale 1ns/1ns
module rxtp_afc_hold
	import rxtp_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic hold_en_i,
	input wire logic ask_mode_i,
	input wire logic preamble_det_i,
	input wire logic rx_restart_i,
	output logic afc_run_o
);
	logic afc_run_ff;
	logic nxt_afc_run;

	// Freeze is sticky until a new reception starts or ASK mode is set; clearing the option releases it at once
	always_comb begin
		nxt_afc_run = afc_run_ff;
		if (rx_restart_i || !hold_en_i || ask_mode_i) begin
			nxt_afc_run = 1'b1;
		end else if (preamble_det_i) begin
			nxt_afc_run = 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			afc_run_ff <= 1'b1;
		end else begin
			afc_run_ff <= nxt_afc_run;
		end
	end

	assign afc_run_o = afc_run_ff;
endmodule

// *** verif/rxtp_regs_monitor.sv ***
// Port checker for the tuning and preamble register bank
`timescale 1ns/1ns
module rxtp_regs_monitor
	import rxtp_pkg::*;
(
	input wire logic CLK_I,
	input wire logic ARST_N_I,
	input wire logic SDA_OE_O,
	input wire logic ASK_MODE_I,
	input wire logic PREAMBLE_DET_I,
	input wire logic RX_RESTART_I,
	input wire logic AFC_RUN_O,
	input wire logic [23:0] LO_TUNING_WORD_O,
	input wire logic [4:0] SYNC_LENGTH_O,
	input wire logic [15:0] SYNC_PATTERN_O
);
	logic [2:0] cyc_ff;
	logic early;
	// Cycles since release; no bus write can land this early, so reset values must show
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			cyc_ff <= 3'h0;
		end else if (cyc_ff != 3'h7) begin
			cyc_ff <= cyc_ff + 3'h1;
		end
	end
	assign early = cyc_ff < 3'h4;
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!ARST_N_I);
	// Freeze only follows a detect outside ASK with no restart
	property p_afc_frz;
		$fell(AFC_RUN_O) |-> $past(PREAMBLE_DET_I) && !$past(ASK_MODE_I) && !$past(RX_RESTART_I);
	endproperty
	a_afc_frz: assert property (p_afc_frz) else $error("afc froze without cause");
	property p_afc_ask;
		ASK_MODE_I |=> AFC_RUN_O;
	endproperty
	a_afc_ask: assert property (p_afc_ask) else $error("afc frozen in ask mode");
	property p_afc_rst;
		RX_RESTART_I |=> AFC_RUN_O;
	endproperty
	a_afc_rst: assert property (p_afc_rst) else $error("afc not released");
	property p_lo_hi;
		early |-> LO_TUNING_WORD_O[23:16] == 8'h13;
	endproperty
	a_lo_hi: assert property (p_lo_hi) else $error("lo high reset wrong");
	property p_lo_mid;
		early |-> LO_TUNING_WORD_O[15:8] == 8'ha9;
	endproperty
	a_lo_mid: assert property (p_lo_mid) else $error("lo mid reset wrong");
	property p_lo_low;
		early |-> LO_TUNING_WORD_O[7:0] == 8'h9a;
	endproperty
	a_lo_low: assert property (p_lo_low) else $error("lo low reset wrong");
	property p_len_rst;
		early |-> SYNC_LENGTH_O == 5'h10;
	endproperty
	a_len_rst: assert property (p_len_rst) else $error("length reset wrong");
	property p_len_rng;
		SYNC_LENGTH_O inside {[5'h01:5'h10]};
	endproperty
	a_len_rng: assert property (p_len_rng) else $error("length out of range");
	property p_pat_lo;
		early |-> SYNC_PATTERN_O[7:0] == 8'h00;
	endproperty
	a_pat_lo: assert property (p_pat_lo) else $error("pattern low reset wrong");
	property p_pat_hi;
		early |-> SYNC_PATTERN_O[15:8] == 8'h00;
	endproperty
	a_pat_hi: assert property (p_pat_hi) else $error("pattern high reset wrong");
	c_frz: cover property ($fell(AFC_RUN_O));
	c_ack: cover property ($rose(SDA_OE_O));
	c_lo: cover property (!$stable(LO_TUNING_WORD_O));
endmodule
bind rxtp_regs_top rxtp_regs_monitor i_mon (.CLK_I(CLK_I), .ARST_N_I(ARST_N_I),
	.SDA_OE_O(SDA_OE_O), .ASK_MODE_I(ASK_MODE_I), .PREAMBLE_DET_I(PREAMBLE_DET_I),
	.RX_RESTART_I(RX_RESTART_I), .AFC_RUN_O(AFC_RUN_O), .LO_TUNING_WORD_O(LO_TUNING_WORD_O),
	.SYNC_LENGTH_O(SYNC_LENGTH_O), .SYNC_PATTERN_O(SYNC_PATTERN_O));

// *** verif/tb.sv ***
// Self-checking bench for the tuning and preamble register bank
`timescale 1ns/1ns
module tb
	import rxtp_pkg::*;
;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic scl = 1'b1;
	logic sda_m = 1'b1;
	logic [7:0] signal_strength = 8'h00;
	logic signal_strength_vld = 1'b0;
	logic ask = 1'b0;
	logic det = 1'b0;
	logic rst_rx = 1'b0;
	logic sda_o, sda_oe, afc;
	logic [23:0] lo;
	logic [4:0] len;
	logic [15:0] pat;
	int err_total = 0;
	int num_checks = 0;
	int cyc = 0;
	// Open-drain wire: low when either party pulls
	wire sda_w = sda_m & ~(sda_oe & ~sda_o);
	rxtp_regs_top #(.DEV_ADDR(7'h38)) i_dut (.CLK_I(clk), .ARST_N_I(arst_n), .SCL_I(scl),
		.SDA_I(sda_w), .SDA_O(sda_o), .SDA_OE_O(sda_oe), .SIGNAL_STRENGTH_I(signal_strength), .SIGNAL_STRENGTH_VLD_I(signal_strength_vld),
		.ASK_MODE_I(ask), .PREAMBLE_DET_I(det), .RX_RESTART_I(rst_rx), .AFC_RUN_O(afc),
		.LO_TUNING_WORD_O(lo), .SYNC_LENGTH_O(len), .SYNC_PATTERN_O(pat));
	always #2 clk = ~clk;
	task automatic stop_test;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Hang guard, well above the roughly 19k cycles the scenarios need
	always @(posedge clk) begin
		cyc++;
		if (cyc == 80000) begin
			err_total++;
			stop_test();
		end
	end
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic ck(input int n);
		repeat (n) @(posedge clk);
	endtask
	// SDA moves only while SCL is low; phases kept at 8 cycles or more
	task automatic i2c_bit(input logic b, output logic r);
		sda_m <= b;
		ck(8);
		scl <= 1'b1;
		ck(8);
		r = sda_w;
		scl <= 1'b0;
		ck(2);
	endtask
	task automatic i2c_start;
		sda_m <= 1'b1;
		ck(8);
		scl <= 1'b1;
		ck(8);
		sda_m <= 1'b0;
		ck(8);
		scl <= 1'b0;
		ck(2);
	endtask
	task automatic i2c_stop;
		sda_m <= 1'b0;
		ck(8);
		scl <= 1'b1;
		ck(8);
		sda_m <= 1'b1;
		ck(8);
	endtask
	task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic a);
		for (int i = 7; i >= 0; i--) begin
			i2c_bit(d[i], q[i]);
		end
		i2c_bit(1'b1, a);
	endtask
	task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
		logic [7:0] q;
		logic a0, a1, a2;
		i2c_start();
		xfer(8'h70, q, a0);
		xfer(ofs, q, a1);
		xfer(d, q, a2);
		i2c_stop();
		chk({21'h0, a0, a1, a2}, 24'h0);
	endtask
	// Pointer write, repeated start, one byte read, master NACK ends it
	task automatic rchk(input logic [7:0] ofs, input logic [7:0] e);
		logic [7:0] q;
		logic a;
		i2c_start();
		xfer(8'h70, q, a);
		xfer(ofs, q, a);
		i2c_start();
		xfer(8'h71, q, a);
		xfer(8'hff, q, a);
		i2c_stop();
		chk({16'h0, q}, {16'h0, e});
	endtask
	task automatic pulse_det;
		det <= 1'b1;
		ck(1);
		det <= 1'b0;
		ck(2);
	endtask
	task automatic t_reset;
		chk(lo, 24'h13a99a);
		chk({19'h0, len}, 24'h10);
		chk({8'h0, pat}, 24'h0);
		rchk(RXTP_OFS_AFC_HOLD, 8'h00);
		rchk(RXTP_OFS_LO_HIGH, 8'h13);
		rchk(RXTP_OFS_LO_MID, 8'ha9);
		rchk(RXTP_OFS_LO_LOW, 8'h9a);
		rchk(RXTP_OFS_SYNC_LEN, 8'h0f);
		rchk(RXTP_OFS_SYNC_LOW, 8'h00);
		rchk(RXTP_OFS_SYNC_HIGH, 8'h00);
		rchk(RXTP_OFS_SIGNAL_STRENGTH, 8'h00);
	endtask
	task automatic t_lo;
		wr(RXTP_OFS_LO_HIGH, 8'h5c);
		wr(RXTP_OFS_LO_MID, 8'h3e);
		wr(RXTP_OFS_LO_LOW, 8'hc1);
		chk(lo, 24'h5c3ec1);
		rchk(RXTP_OFS_LO_HIGH, 8'h5c);
		rchk(RXTP_OFS_LO_MID, 8'h3e);
		rchk(RXTP_OFS_LO_LOW, 8'hc1);
	endtask
	// Field boundary 0 and a value with reserved bits set
	task automatic t_sync;
		wr(RXTP_OFS_SYNC_LEN, 8'h00);
		chk({19'h0, len}, 24'h1);
		wr(RXTP_OFS_SYNC_LEN, 8'hf7);
		chk({19'h0, len}, 24'h8);
		rchk(RXTP_OFS_SYNC_LEN, 8'h07);
		wr(RXTP_OFS_SYNC_LOW, 8'h5a);
		wr(RXTP_OFS_SYNC_HIGH, 8'ha5);
		chk({8'h0, pat}, 24'ha55a);
		rchk(RXTP_OFS_SYNC_LOW, 8'h5a);
		rchk(RXTP_OFS_SYNC_HIGH, 8'ha5);
	endtask
	task automatic t_signal_strength;
		signal_strength <= 8'hc3;
		signal_strength_vld <= 1'b1;
		ck(1);
		signal_strength_vld <= 1'b0;
		signal_strength <= 8'h00;
		ck(2);
		rchk(RXTP_OFS_SIGNAL_STRENGTH, 8'hc3);
		wr(RXTP_OFS_SIGNAL_STRENGTH, 8'h11);
		rchk(RXTP_OFS_SIGNAL_STRENGTH, 8'hc3);
		rchk(8'h0f, 8'h00);
	endtask
	task automatic t_afc;
		wr(RXTP_OFS_AFC_HOLD, 8'h40);
		rchk(RXTP_OFS_AFC_HOLD, 8'h40);
		pulse_det();
		chk({23'h0, afc}, 24'h0);
		rst_rx <= 1'b1;
		ck(1);
		rst_rx <= 1'b0;
		ck(2);
		chk({23'h0, afc}, 24'h1);
		ask <= 1'b1;
		pulse_det();
		chk({23'h0, afc}, 24'h1);
		ask <= 1'b0;
		wr(RXTP_OFS_AFC_HOLD, 8'h00);
		pulse_det();
		chk({23'h0, afc}, 24'h1);
	endtask
	// A foreign address must not be acknowledged
	task automatic t_badaddr;
		logic [7:0] q;
		logic a;
		i2c_start();
		xfer(8'h72, q, a);
		i2c_stop();
		chk({23'h0, a}, 24'h1);
		chk({22'h0, sda_o, sda_oe}, 24'h0);
	endtask
	initial begin
		ck(3);
		arst_n <= 1'b1;
		ck(8);
		t_reset();
		t_lo();
		t_sync();
		t_signal_strength();
		t_afc();
		t_badaddr();
		stop_test();
	end
endmodule
